// File: core/pcx_defines.vh
`ifndef PCX_DEFINES_VH
`define PCX_DEFINES_VH

// flag register location, data-space view and the i/o-instruction view
`define PCX_FLAGS_DATA_OFS 8'h3b
`define PCX_IO_SPACE_BASE 8'h20
`define PCX_FLAGS_IO_OFS (`PCX_FLAGS_DATA_OFS - `PCX_IO_SPACE_BASE)

// flag register layout
`define PCX_FLAG_BITS 4
`define PCX_FLAGS_RESET 4'h0
`define PCX_UPPER_READ 4'h0
`define PCX_RDATA_RESET 8'h00

// pin-change groups
`define PCX_NUM_GROUPS 4
`define PCX_GROUP_W 8
`define PCX_NUM_PINS 32

// dedicated interrupt pins and their two-bit sense field
`define PCX_NUM_EXT 3
`define PCX_SENSE_W 2
`define PCX_SENSE_LOW 2'h0
`define PCX_SENSE_ANY 2'h1
`define PCX_SENSE_FALL 2'h2
`define PCX_SENSE_RISE 2'h3

// synchroniser fill count before its output is trusted
`define PCX_SYNC_FILL 2'h3

`endif

// File: core/pcx_sync3.v
`include "pcx_defines.vh"

// three-stage pin synchroniser; a change is taken once stages two and
// three agree, so a single metastable sample never reaches the logic
module pcx_sync3 #(
   parameter W = 1
) (
   // clock and reset
   input wire ref_clk,
   input wire nrst,
   // pins from outside the clock domain
   input wire [W-1:0] async_in,
   // filtered levels
   output reg [W-1:0] stable_q,
   output reg primed_q
);

   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;
   reg [1:0] fill_q;
   wire [W-1:0] agree;

   // only stages two and three are compared, never stage one
   assign agree = ~(s2_q ^ s3_q);

   // shift chain and agreement filter
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s1_q <= {W{1'b0}};
         s2_q <= {W{1'b0}};
         s3_q <= {W{1'b0}};
         stable_q <= {W{1'b0}};
         fill_q <= 2'h0;
         primed_q <= 1'b0;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         stable_q <= (stable_q & ~agree) | (s3_q & agree);
         // the reset value of the chain is not a real pin level
         if (fill_q != `PCX_SYNC_FILL) begin
            fill_q <= fill_q + 2'h1;
         end
         primed_q <= (fill_q == `PCX_SYNC_FILL);
      end
   end

endmodule

// File: core/pcx_ext_irq.v
`include "pcx_defines.vh"

// Operation
// - pins driven as outputs still raise interrupts from their own drive.
// - group n requests on any enabled toggle of inputs 8n+7 to 8n.
// - per-group masks choose which pins may contribute to the group.
// - pin-change detection runs without the i/o clock, waking any sleep.
// - each dedicated pin triggers on falling edge, rising edge, any change or low level.
// - a level-sensed dedicated pin requests for as long as it stays low.
// - edge recognition on dedicated pins needs the running i/o clock.
// - low-level detection on dedicated pins is clock-free and can wake.
// - the i/o clock stops in every sleep mode except idle.
// - a low level must outlast start-up, else the part wakes unserviced.
// - a group request sets its flag, bit 3 for top group to bit 0.
// - vector only when flag, group enable and global enable are all set.
// - a group flag clears when its interrupt routine starts.
// - writing one to a flag bit clears that flag.
// - flag register answers at data offset 0x3b and i/o address 0x1b.
module pcx_ext_irq (
   // clock and reset
   input wire ref_clk,
   input wire nrst,
   // pin-change pins: pad level, port drive and direction (1 = output)
   input wire [31:0] pin_change_pad,
   input wire [31:0] pin_change_drive,
   input wire [31:0] pin_change_dir,
   // dedicated interrupt pins: pad level, port drive and direction
   input wire [2:0] ext_pad,
   input wire [2:0] ext_drive,
   input wire [2:0] ext_dir,
   // configuration held by the surrounding core
   input wire [7:0] pin_change_mask_group0,
   input wire [7:0] pin_change_mask_group1,
   input wire [7:0] pin_change_mask_group2,
   input wire [7:0] pin_change_mask_group3,
   input wire [3:0] pin_change_control,
   input wire [5:0] edge_level_control,
   input wire [2:0] ext_irq_enable,
   input wire status_register_ie,
   // i/o clock running, low in every sleep mode but idle
   input wire io_clk_run,
   // handler entry pulses from the core
   input wire [3:0] group_vector_ack,
   input wire [2:0] ext_vector_ack,
   // register access port
   input wire [7:0] io_addr,
   input wire io_space,
   input wire io_wr,
   input wire io_rd,
   input wire [7:0] io_wdata,
   output reg [7:0] io_rdata,
   // interrupt requests to the core
   output wire pin_change_request_group0,
   output wire pin_change_request_group1,
   output wire pin_change_request_group2,
   output wire pin_change_request_group3,
   output wire [2:0] ext_irq_req,
   // state for the core and the sleep controller
   output wire [3:0] pin_change_flags,
   output wire [2:0] ext_edge_flags,
   output reg wake_req
);

   // any set bit per group of eight
   function [3:0] group_any;
      input [31:0] v;
      integer g;
      begin
         group_any = 4'h0;
         for (g = 0; g < `PCX_NUM_GROUPS; g = g + 1) begin
            group_any[g] = |v[g*`PCX_GROUP_W +: `PCX_GROUP_W];
         end
      end
   endfunction

   // edge match for one dedicated pin; the level mode never sets a flag
   function ext_edge;
      input [1:0] sense;
      input now;
      input prev;
      begin
         case (sense)
            `PCX_SENSE_FALL: ext_edge = prev & ~now;
            `PCX_SENSE_RISE: ext_edge = ~prev & now;
            `PCX_SENSE_ANY: ext_edge = prev ^ now;
            default: ext_edge = 1'b0;
         endcase
      end
   endfunction

   // two-bit sense field of dedicated pin n
   function [1:0] pin_sense;
      input [5:0] ctrl;
      input integer n;
      begin
         pin_sense = ctrl[n*`PCX_SENSE_W +: `PCX_SENSE_W];
      end
   endfunction

   // flag register decode in both address views; the right number in the
   // wrong view is a miss, since it names another register there
   function flag_hit;
      input [7:0] addr;
      input space;
      begin
         if (space) begin
            flag_hit = (addr == `PCX_FLAGS_IO_OFS);
         end else begin
            flag_hit = (addr == `PCX_FLAGS_DATA_OFS);
         end
      end
   endfunction

   wire [31:0] pc_level;
   wire [2:0] ext_level;
   wire [31:0] pc_stable;
   wire [2:0] ext_stable;
   wire pc_primed;
   wire ext_primed;
   wire [31:0] pc_mask;
   wire [31:0] pc_toggle;
   wire [3:0] pc_set;
   wire flags_hit;
   wire [3:0] wr_clear;
   wire [3:0] pc_req;
   wire [2:0] ext_low;

   reg [31:0] pc_prev_q;
   reg [2:0] ext_prev_q;
   reg pc_armed_q;
   reg ext_armed_q;
   reg [3:0] flags_q;
   reg [3:0] flags_d;
   reg [2:0] ext_flag_q;
   reg [2:0] ext_flag_d;
   reg [2:0] ext_hit;
   reg [2:0] ext_req_d;
   integer i;

   // a pin set as output is watched through its own drive, so software
   // can raise an interrupt by writing the port
   // trade-off: the pad of an output pin is ignored, so a clash is unseen
   assign pc_level = (pin_change_dir & pin_change_drive) |
                     (~pin_change_dir & pin_change_pad);
   assign ext_level = (ext_dir & ext_drive) | (~ext_dir & ext_pad);

   // pins cross into the clock domain through three flops
   // both chains arm after the same fill, so every pin starts together
   pcx_sync3 #(
      .W(`PCX_NUM_PINS)
   ) u_pc_sync (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .async_in(pc_level),
      .stable_q(pc_stable),
      .primed_q(pc_primed)
   );

   pcx_sync3 #(
      .W(`PCX_NUM_EXT)
   ) u_ext_sync (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .async_in(ext_level),
      .stable_q(ext_stable),
      .primed_q(ext_primed)
   );

   // masks laid out so group n owns bits 8n+7 down to 8n
   assign pc_mask = {pin_change_mask_group3, pin_change_mask_group2,
                     pin_change_mask_group1, pin_change_mask_group0};

   // toggle is stable level against last level; masked pins are dropped
   // before the group or, so they can never reach a request
   assign pc_toggle = (pc_stable ^ pc_prev_q) & pc_mask &
                      {`PCX_NUM_PINS{pc_armed_q}};
   assign pc_set = group_any(pc_toggle);

   // pin-change history runs on the always-on path, not gated by the
   // i/o clock, so a toggle in deep sleep still sets a flag
   // the armed bit hides the reset value of the history, which is not a
   // real pin level and would otherwise read as a toggle
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pc_prev_q <= {`PCX_NUM_PINS{1'b0}};
         pc_armed_q <= 1'b0;
      end else begin
         pc_prev_q <= pc_stable;
         pc_armed_q <= pc_primed;
      end
   end

   // one decode serves both the write clear and the read
   assign flags_hit = flag_hit(io_addr, io_space);
   // only ones clear; zeros and upper bits are ignored
   assign wr_clear = (io_wr & flags_hit) ?
                     io_wdata[`PCX_FLAG_BITS-1:0] : 4'h0;

   // set beats clear so a toggle landing on the clear cycle is kept
   always @* begin
      flags_d = (flags_q & ~(wr_clear | group_vector_ack)) | pc_set;
   end

   // flag store, the only state the register port can change
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         flags_q <= `PCX_FLAGS_RESET;
      end else begin
         flags_q <= flags_d;
      end
   end

   // reads have no side effect; unmapped addresses read zero
   // limitation: a read in the clear cycle returns the flags before it
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         io_rdata <= `PCX_RDATA_RESET;
      end else if (io_rd) begin
         if (flags_hit) begin
            io_rdata <= {`PCX_UPPER_READ, flags_q};
         end else begin
            io_rdata <= `PCX_RDATA_RESET;
         end
      end
   end

   // a group vectors only with its flag, its enable and the global bit
   // requests follow the flag store, so they drop together with the flag
   assign pc_req = flags_q & pin_change_control &
                   {`PCX_FLAG_BITS{status_register_ie}};
   assign pin_change_request_group0 = pc_req[0];
   assign pin_change_request_group1 = pc_req[1];
   assign pin_change_request_group2 = pc_req[2];
   assign pin_change_request_group3 = pc_req[3];
   assign pin_change_flags = flags_q;

   // low level straight from the synchronised pin, no i/o clock involved
   // limitation: the core must only sample it once start-up has ended
   assign ext_low = ~ext_stable & {`PCX_NUM_EXT{ext_armed_q}};

   // once armed, edge history only advances while the i/o clock runs; after a sleep
   // the first compare is against the level held at sleep entry
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ext_prev_q <= {`PCX_NUM_EXT{1'b0}};
         ext_armed_q <= 1'b0;
      end else begin
         ext_armed_q <= ext_primed;
         // until armed the history tracks the pin even in sleep, so the
         // zero left by reset never shows up as a rising edge later
         if (io_clk_run || !ext_armed_q) begin
            ext_prev_q <= ext_stable;
         end
      end
   end

   // per-pin edge match, flag update and request select
   always @* begin
      ext_hit = 3'h0;
      ext_req_d = 3'h0;
      ext_flag_d = ext_flag_q;
      for (i = 0; i < `PCX_NUM_EXT; i = i + 1) begin
         // edges are only seen with the i/o clock running
         ext_hit[i] = io_clk_run & ext_armed_q &
            ext_edge(pin_sense(edge_level_control, i),
                     ext_stable[i], ext_prev_q[i]);
         ext_flag_d[i] = (ext_flag_q[i] & ~ext_vector_ack[i]) | ext_hit[i];
         if (pin_sense(edge_level_control, i) == `PCX_SENSE_LOW) begin
            // no latch: a level gone before start-up ends asks nothing
            ext_req_d[i] = ext_low[i];
         end else begin
            ext_req_d[i] = ext_flag_q[i];
         end
      end
   end

   // edge flags, held until the core enters the handler
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ext_flag_q <= 3'h0;
      end else begin
         ext_flag_q <= ext_flag_d;
      end
   end

   // the pin enable and the global bit gate level and edge requests
   // alike; an edge flag is kept while they are off
   assign ext_irq_req = ext_req_d & ext_irq_enable &
                        {`PCX_NUM_EXT{status_register_ie}};
   assign ext_edge_flags = ext_flag_q;

   // wake ignores the global bit so a sleeping core is brought back even
   // with interrupts off; level wake is only possible in level mode
   // limitation: wake follows the flag one cycle later
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wake_req <= 1'b0;
      end else begin
         wake_req <= (|(flags_q & pin_change_control)) |
                     (|(ext_req_d & ext_irq_enable));
      end
   end

endmodule

// File: verif/pcx_pin_src.sv
module pcx_pin_src (
   // clock
   input wire logic ref_clk,
   // levels asked for by the bench
   input wire logic [31:0] want,
   input wire logic [2:0] want_ext,
   // pads toward the block
   output logic [31:0] pad = '1,
   output logic [2:0] xpad = '1
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [34:0] hold_q = '1;
   // pads move at the falling edge; a low level stays until asked otherwise
   always @(posedge ref_clk) hold_q <= {want_ext, want};
   always @(negedge ref_clk) {xpad, pad} <= hold_q;
endmodule

// File: verif/pcx_ext_irq_asserts.sv
module pcx_chk (
   // clock and reset
   input wire ref_clk,
   input wire nrst,
   // pins, masks and enables
   input wire [31:0] pin_change_pad,
   input wire [31:0] pin_change_drive,
   input wire [31:0] pin_change_dir,
   input wire [7:0] pin_change_mask_group0,
   input wire [3:0] pin_change_control,
   input wire status_register_ie,
   input wire [3:0] group_vector_ack,
   // register port
   input wire [7:0] io_addr,
   input wire io_space,
   input wire io_wr,
   input wire io_rd,
   input wire [7:0] io_wdata,
   input wire [7:0] io_rdata,
   // results
   input wire pin_change_request_group0,
   input wire [3:0] pin_change_flags
);
   wire hit;
   wire [95:0] pins;
   // the wrong view of an address is a miss, not an alias
   assign hit = io_space ? io_addr == 8'h1b : io_addr == 8'h3b;
   assign pins = {pin_change_pad, pin_change_drive, pin_change_dir};
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);
   a_upper_zero: assert property (io_rdata[7:4] == 4'h0)
      else $error("upper flag bits set");
   a_data_read: assert property (io_rd && !io_space && io_addr == 8'h3b
      |=> io_rdata == {4'h0, $past(pin_change_flags)})
      else $error("data view read wrong");
   a_io_read: assert property (io_rd && io_space && io_addr == 8'h1b
      |=> io_rdata == {4'h0, $past(pin_change_flags)})
      else $error("io view read wrong");
   a_miss_zero: assert property (io_rd && !hit
      |=> io_rdata == 8'h00) else $error("unmapped read not zero");
   a_zero_keeps: assert property (io_wr && hit && group_vector_ack == 4'h0
      |=> ($past(pin_change_flags) & ~$past(io_wdata[3:0])
      & ~pin_change_flags) == 4'h0) else $error("flag lost on zero write");
   // quiet pins for eight cycles: no toggle is still in flight
   a_one_clears: assert property ($stable(pins) [*8] ##0 (io_wr && hit)
      |=> (pin_change_flags & $past(io_wdata[3:0])) == 4'h0)
      else $error("flag kept after one write");
   a_ack_clears: assert property ($stable(pins) [*8] ##0 group_vector_ack[0]
      |=> !pin_change_flags[0]) else $error("flag kept at handler entry");
   a_group_req: assert property (pin_change_request_group0 ==
      (pin_change_flags[0] && pin_change_control[0] && status_register_ie))
      else $error("group request wrong");
   a_mask_blocks: assert property ((pin_change_mask_group0 == 8'h00) [*8]
      |-> !$rose(pin_change_flags[0])) else $error("masked pin set flag");
endmodule

bind pcx_ext_irq pcx_chk u_chk (.ref_clk, .nrst, .pin_change_pad,
   .pin_change_drive, .pin_change_dir, .pin_change_mask_group0,
   .pin_change_control, .status_register_ie, .group_vector_ack, .io_addr,
   .io_space, .io_wr, .io_rd, .io_wdata, .io_rdata,
   .pin_change_request_group0, .pin_change_flags);

// File: verif/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic [31:0] want = '0, drv = '0, dir = '0;
   logic [2:0] want_ext = 3'h7, eack = 3'h0, xen = 3'h1, xdir = 3'h0;
   logic [7:0] msk [4] = '{default: 8'h00};
   logic [3:0] ctrl = 4'h0, gack = 4'h0;
   logic [5:0] sense = 6'h00;
   logic ie = 1'b0, run = 1'b1, sp = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [7:0] addr = 8'h00, wd = 8'h00, exp_f = 8'h00;
   wire [31:0] pad;
   wire [7:0] rdat;
   wire [2:0] xpad, xreq, xfl;
   wire [3:0] req, flg;
   wire wk;
   int seed = 773, errors = 0, checks_done = 0, cyc = 0, g;
   pcx_pin_src src (.ref_clk, .want, .want_ext, .pad, .xpad);
   pcx_ext_irq DUT (.ref_clk, .nrst, .pin_change_pad(pad),
      .pin_change_drive(drv), .pin_change_dir(dir), .ext_pad(xpad),
      .ext_drive(3'h0), .ext_dir(xdir), .pin_change_mask_group0(msk[0]),
      .pin_change_mask_group1(msk[1]), .pin_change_mask_group2(msk[2]),
      .pin_change_mask_group3(msk[3]), .pin_change_control(ctrl),
      .edge_level_control(sense), .ext_irq_enable(xen),
      .status_register_ie(ie), .io_clk_run(run), .group_vector_ack(gack),
      .ext_vector_ack(eack), .io_addr(addr), .io_space(sp), .io_wr(wr),
      .io_rd(rd), .io_wdata(wd), .io_rdata(rdat),
      .pin_change_request_group0(req[0]), .pin_change_request_group1(req[1]),
      .pin_change_request_group2(req[2]), .pin_change_request_group3(req[3]),
      .ext_irq_req(xreq), .pin_change_flags(flg), .ext_edge_flags(xfl),
      .wake_req(wk));
   always #2 ref_clk = ~ref_clk;
   // a hung run is cut short and counted as a mismatch
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         end_sim();
      end
   end
   task automatic chk(input string nm, input logic [7:0] seen, e);
      checks_done++;
      if (seen !== e) begin
         errors++;
         $display("BAD %s exp %h seen %h", nm, e, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // one register access; read data is settled by the next falling edge
   task automatic acc(input logic w, input logic [7:0] a, input logic s,
         input logic [7:0] d);
      {wr, rd, addr, sp, wd} = {w, !w, a, s, d};
      step(1);
      {wr, rd} = 2'b00;
      // an idle edge between accesses keeps each strobe a single pulse
      step(1);
   endtask
   task automatic rdr(input logic [7:0] a, input logic s, input logic [7:0] e);
      acc(1'b0, a, s, 8'h00);
      chk("flags", rdat, e);
   endtask
   // six edges of latency, ten waited for margin
   task automatic tog(input int n);
      want[n] = ~want[n];
      step(10);
   endtask
   task automatic xset(input logic l, e);
      want_ext[0] = l;
      step(10);
      chk("ext_req", {7'h0, xreq[0]}, {7'h0, e});
      chk("ext_flag", {7'h0, xfl[0]}, {7'h0, e && sense[1:0] != 2'h0});
      eack = 3'h1;
      step(1);
      eack = 3'h0;
      chk("ext_clr", {7'h0, xfl[0]}, 8'h00);
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      want = $random(seed);
      step(12);
      nrst = 1'b1;
      step(8);
      rdr(8'h1b, 1'b1, exp_f);
      // one random pin per group, only that pin unmasked
      for (g = 0; g < 4; g++) begin
         msk[g] = 8'h01 << ($random(seed) & 7);
         tog(g * 8 + $clog2(msk[g]));
         exp_f[g] = 1'b1;
         rdr(8'h3b, 1'b0, exp_f);
      end
      ie = 1'b1;
      for (g = 0; g < 5; g++) begin
         ctrl = 4'($random(seed));
         ie = g < 4;
         step(1);
         chk("req", {4'h0, req}, exp_f & {4'h0, ctrl} & {8{ie}});
         chk("wake", {7'h0, wk}, {7'h0, |(exp_f[3:0] & ctrl)});
         chk("flags_out", {4'h0, flg}, exp_f);
      end
      rdr(8'h1b, 1'b0, 8'h00);
      acc(1'b1, 8'h3b, 1'b1, 8'h0f);
      acc(1'b1, 8'h3b, 1'b0, 8'hf0);
      rdr(8'h3b, 1'b0, exp_f);
      acc(1'b1, 8'h1b, 1'b1, 8'h02);
      exp_f[1] = 1'b0;
      rdr(8'h3b, 1'b0, exp_f);
      gack = 4'h1;
      step(1);
      gack = 4'h0;
      exp_f[0] = 1'b0;
      rdr(8'h3b, 1'b0, exp_f);
      // masked pins, also beside enabled group mates
      msk = '{default: 8'h00};
      for (g = 0; g < 6; g++)
         tog($random(seed) & 31);
      msk[1] = 8'hfe;
      tog(8);
      rdr(8'h3b, 1'b0, exp_f);
      $display("test flags done");
      acc(1'b1, 8'h3b, 1'b0, 8'h0c);
      exp_f = 8'h00;
      rdr(8'h3b, 1'b0, exp_f);
      // an output pin is watched through its drive, i/o clock stopped
      run = 1'b0;
      drv[17] = want[17];
      dir[17] = 1'b1;
      msk[2] = 8'h02;
      step(10);
      drv[17] = ~drv[17];
      step(10);
      exp_f[2] = 1'b1;
      rdr(8'h3b, 1'b0, exp_f);
      acc(1'b1, 8'h3b, 1'b0, 8'h04);
      rdr(8'h3b, 1'b0, 8'h00);
      // dedicated pin: edges unseen while stopped, then the fall, rise and low modes
      ie = 1'b1;
      sense = 6'h02;
      xset(1'b0, 1'b0);
      xset(1'b1, 1'b0);
      run = 1'b1;
      xset(1'b0, 1'b1);
      sense = 6'h03;
      xset(1'b1, 1'b1);
      sense = 6'h00;
      run = 1'b0;
      xset(1'b0, 1'b1);
      xset(1'b0, 1'b1);
      xen = 3'h0;
      step(1);
      chk("ext_off", {7'h0, xreq[0]}, 8'h00);
      xen = 3'h1;
      xset(1'b1, 1'b0);
      // a dedicated pin set as output is watched through its drive
      xdir = 3'h1;
      step(10);
      chk("ext_out", {7'h0, xreq[0]}, 8'h01);
      xdir = 3'h0;
      $display("test dedicated done");
      end_sim();
   end
endmodule
